//--- design/tiu_pkg.sv
`default_nettype none
package tiu_pkg;
  // mode select codes {buffer, single}
  localparam logic [1:0] MODE_UNBUF = 2'h1;
  localparam logic [1:0] MODE_BUF   = 2'h2;
  // edge/level select codes
  localparam logic [1:0] ELS_PRESET = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR  = 2'h2;
  localparam logic [1:0] ELS_SET    = 2'h3;
  // prescaler
  localparam logic [2:0] PS_EXT     = 3'h7;
  localparam int unsigned DIV_W     = 6;
  localparam logic [5:0] DIV_RST    = 6'h00;
  // external count clock limit, sampled on mclk
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned EXT_MAX_HZ = 4_000_000;
  localparam int unsigned EXT_MIN_CYC = (CLK_HZ + EXT_MAX_HZ - 1) / EXT_MAX_HZ;
  // reset values
  localparam logic [3:0] PIN_RST    = 4'h0;
  localparam logic [1:0] ACT_RST    = 2'h0;
endpackage
`default_nettype wire

//--- design/tiu_prescaler.sv
`default_nettype none
module tiu_prescaler (
  input  wire logic mclk,
  input  wire logic reset,
  tiu_tick_if.pre   tk
);
  typedef struct packed {
    logic [tiu_pkg::DIV_W-1:0] div;
    logic                      ext_prev;
    logic                      tick;
  } tiu_pre_s;

  tiu_pre_s q;
  tiu_pre_s d;
  logic [tiu_pkg::DIV_W:0] mask;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    d.ext_prev = tk.ext_clk;
    mask = (7'h01 << tk.ps) - 7'h01;
    if (tk.clr) begin
      d.div = tiu_pkg::DIV_RST;
    end else if (tk.run) begin
      if (tk.ps == tiu_pkg::PS_EXT) begin
        d.tick = tk.ext_clk && !q.ext_prev; // RULE19
      end else begin
        d.div = q.div + 6'h01;
        d.tick = (q.div & mask[5:0]) == mask[5:0]; // RULE24
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tk.tick = q.tick;

  ext_tick_a: assert property (@(posedge mclk) disable iff (reset) // RULE19
    (tk.run && !tk.clr && tk.ps == tiu_pkg::PS_EXT && tk.ext_clk && !q.ext_prev)
    |=> tk.tick)
    else $error("external clock edge gave no tick");
  div1_tick_a: assert property (@(posedge mclk) disable iff (reset) // RULE24
    (tk.run && !tk.clr && tk.ps == 3'h0) |=> tk.tick)
    else $error("divide by one missed a tick");
endmodule
`default_nettype wire

//--- design/tiu_pwm_timer.sv
// Overview of operation
// [RULE1] link bit on channel 0 joins channels 0,1 onto pin 0, channel 0 first
// [RULE2] partner write takes over at next overflow; last written wins each overflow
// [RULE3] link bit on channel 2 joins channels 2,3 onto pin 2 likewise
// [RULE4] linked pair uses even controls; odd controls ignored, odd pin released
// [RULE5] buffer select beats single select on the even channel
// [RULE6] software writes only the inactive channel of a linked pair
// [RULE7] software halts, clears, sets period and width, configures, then runs
// [RULE8] mode code 01 unbuffered, 10 buffered
// [RULE9] level code 10 clears on compare, 11 sets on compare
// [RULE10] toggle on overflow clear means no overflow toggle, 0% duty
// [RULE11] max duty with toggle on overflow holds 100% duty
// [RULE12] software never uses toggle on compare for pwm
// [RULE13] overflow flag set at period limit; request only when enabled
// [RULE14] channel flag set on capture or compare; request only when enabled
// [RULE15] timer runs in wait mode; enabled request wakes the processor
// [RULE16] stop mode freezes the timer and keeps its state
// [RULE17] debug break halts the counter
// [RULE18] in break flags clear only with break clear enable set
// [RULE19] prescale code all ones selects external count clock
// [RULE20] external clock at most 4 MHz and half the bus clock
// [RULE21] each pin capture or compare; only pins 0,2 buffered
// [RULE22] flag clears by read while set then write 0; new event wins
// [RULE23] counter restarts from zero after the period limit
// [RULE24] prescale codes divide by 1 to 64
// [RULE25] overflow and channel requests are separate level outputs
`default_nettype none
module tiu_pwm_timer #(
  parameter int unsigned CW = 16
) (
  input  wire logic            mclk,
  input  wire logic            reset,
  input  wire logic            counter_halt,
  input  wire logic            counter_reset,
  input  wire logic [2:0]      prescale_select,
  input  wire logic [CW-1:0]   period_limit,
  input  wire logic            overflow_irq_enable,
  input  wire logic            break_clear_enable,
  input  wire logic            debug_break,
  input  wire logic            stop_mode,
  input  wire logic            external_count_clock,
  input  wire logic            overflow_flag_read,
  input  wire logic            overflow_flag_clear_wr,
  input  wire logic [3:0]      buffer_mode_select,
  input  wire logic [3:0]      single_mode_select,
  input  wire logic [7:0]      edge_level_select,
  input  wire logic [3:0]      toggle_on_overflow,
  input  wire logic [3:0]      max_duty_bit,
  input  wire logic [3:0]      channel_irq_enable,
  input  wire logic [3:0]      compare_wr,
  input  wire logic [CW-1:0]   compare_wr_data,
  input  wire logic [3:0]      channel_flag_read,
  input  wire logic [3:0]      channel_flag_clear_wr,
  input  wire logic [3:0]      channel_pin_in,
  output logic [CW-1:0]        counter_value,
  output logic [4*CW-1:0]      channel_compare_value,
  output logic                 overflow_flag,
  output logic                 overflow_irq,
  output logic [3:0]           channel_event_flag,
  output logic [3:0]           channel_irq,
  output logic [3:0]           channel_pin_out,
  output logic [3:0]           channel_pin_oe,
  output logic [1:0]           pair_active_odd,
  output logic                 wake_request
);
  if (CW < 8 || CW > 32) begin : g_bad_width
    $error("counter width must be 8 to 32");
  end

  typedef struct packed {
    logic [CW-1:0]   cnt;
    logic [4*CW-1:0] cmp;
    logic            ovf_f;
    logic            ovf_arm;
    logic            ovf_irq;
    logic            wake;
    logic [3:0]      ch_f;
    logic [3:0]      ch_arm;
    logic [3:0]      ch_irq;
    logic [3:0]      pin;
    logic [3:0]      oe;
    logic [3:0]      pin_prev;
    logic [1:0]      act;
    logic [1:0]      last_wr;
  } tiu_state_s;

  tiu_state_s q;
  tiu_state_s d;
  logic       run;
  logic       cnt_tick;
  logic       ovf_ev;
  logic       clr_ok;
  logic [3:0] ch_ev;

  tiu_tick_if tk ();

  assign tk.run     = run;
  assign tk.clr     = counter_reset;
  assign tk.ps      = prescale_select;
  assign tk.ext_clk = external_count_clock;

  tiu_prescaler u_pre (
    .mclk  (mclk),
    .reset (reset),
    .tk    (tk)
  );

  // stop, halt and break all freeze counting
  assign run      = !counter_halt && !debug_break && !stop_mode; // RULE16 RULE17
  assign cnt_tick = run && tk.tick && !counter_reset;
  assign ovf_ev   = cnt_tick && (q.cnt == period_limit); // RULE13
  assign clr_ok   = !debug_break || break_clear_enable; // RULE18

  always_comb begin
    logic [1:0]    els;
    logic [1:0]    mode;
    logic          buf_m;
    logic          ign;
    logic          outm;
    logic          capm;
    logic          match;
    logic          rise;
    logic          fall;
    logic [CW-1:0] cv;
    els   = 2'h0;
    mode  = 2'h0;
    buf_m = 1'b0;
    ign   = 1'b0;
    outm  = 1'b0;
    capm  = 1'b0;
    match = 1'b0;
    rise  = 1'b0;
    fall  = 1'b0;
    cv    = '0;
    d     = q;
    ch_ev = 4'h0;

    if (counter_reset) begin
      d.cnt = '0;
    end else if (ovf_ev) begin
      d.cnt = '0; // RULE23
    end else if (cnt_tick) begin
      d.cnt = q.cnt + CW'(1);
    end

    // pair tracking: last written channel takes over at overflow
    for (int p = 0; p < 2; p++) begin
      if (!buffer_mode_select[2*p]) begin
        d.act[p]     = 1'b0; // RULE1 RULE3
        d.last_wr[p] = 1'b0;
      end else begin
        if (compare_wr[2*p+1]) begin
          d.last_wr[p] = 1'b1; // RULE2
        end else if (compare_wr[2*p]) begin
          d.last_wr[p] = 1'b0;
        end
        if (ovf_ev) begin
          d.act[p] = d.last_wr[p]; // RULE2 RULE3
        end
      end
    end

    for (int i = 0; i < 4; i++) begin
      els   = edge_level_select[2*i+:2];
      buf_m = (i % 2 == 0) && buffer_mode_select[i]; // RULE5 RULE21
      ign   = (i % 2 == 1) && buffer_mode_select[i & 2]; // RULE4
      mode  = {buf_m, single_mode_select[i]};
      outm  = (mode == tiu_pkg::MODE_UNBUF) || ((mode & tiu_pkg::MODE_BUF) != 2'h0); // RULE8
      capm  = !outm && (els != tiu_pkg::ELS_PRESET);
      cv    = (buf_m && q.act[i/2]) ? q.cmp[(i|1)*CW+:CW] : q.cmp[i*CW+:CW]; // RULE1 RULE3
      match = cnt_tick && (q.cnt == cv);
      rise  = channel_pin_in[i] && !q.pin_prev[i];
      fall  = !channel_pin_in[i] && q.pin_prev[i];
      d.pin_prev[i] = channel_pin_in[i];
      d.oe[i] = 1'b0;
      if (compare_wr[i]) begin
        d.cmp[i*CW+:CW] = compare_wr_data;
      end
      if (ign) begin
        d.oe[i] = 1'b0; // RULE4
      end else if (els == tiu_pkg::ELS_PRESET) begin
        d.pin[i] = !single_mode_select[i];
      end else if (outm) begin
        d.oe[i] = 1'b1; // RULE21
        if (match) begin
          ch_ev[i] = 1'b1; // RULE14
          case (els)
            tiu_pkg::ELS_TOGGLE: d.pin[i] = !q.pin[i];
            tiu_pkg::ELS_CLEAR:  d.pin[i] = 1'b0; // RULE9
            default:             d.pin[i] = 1'b1; // RULE9
          endcase
        end
        if (ovf_ev && toggle_on_overflow[i]) begin
          d.pin[i] = !d.pin[i]; // RULE10
        end
        if (max_duty_bit[i] && toggle_on_overflow[i]) begin
          d.pin[i] = (els != tiu_pkg::ELS_SET); // RULE11
        end
      end else if (capm && run) begin
        if ((rise && els[0]) || (fall && els[1])) begin
          ch_ev[i] = 1'b1; // RULE14
          d.cmp[i*CW+:CW] = q.cnt;
        end
      end

      // two-step clear; a new event always wins
      if (channel_flag_read[i] && q.ch_f[i] && clr_ok) begin
        d.ch_arm[i] = 1'b1; // RULE22
      end
      if (channel_flag_clear_wr[i] && q.ch_arm[i] && clr_ok) begin
        d.ch_f[i]   = 1'b0; // RULE22 RULE18
        d.ch_arm[i] = 1'b0;
      end
      if (ch_ev[i]) begin
        d.ch_f[i]   = 1'b1; // RULE14 RULE22
        d.ch_arm[i] = 1'b0;
      end
      d.ch_irq[i] = d.ch_f[i] && channel_irq_enable[i]; // RULE14 RULE25
    end

    if (overflow_flag_read && q.ovf_f && clr_ok) begin
      d.ovf_arm = 1'b1; // RULE22
    end
    if (overflow_flag_clear_wr && q.ovf_arm && clr_ok) begin
      d.ovf_f   = 1'b0; // RULE22 RULE18
      d.ovf_arm = 1'b0;
    end
    if (ovf_ev) begin
      d.ovf_f   = 1'b1; // RULE13 RULE22
      d.ovf_arm = 1'b0;
    end
    d.ovf_irq = d.ovf_f && overflow_irq_enable; // RULE13 RULE25
    d.wake    = d.ovf_irq || (d.ch_irq != 4'h0); // RULE15
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      q         <= '0;
      q.pin     <= tiu_pkg::PIN_RST;
      q.act     <= tiu_pkg::ACT_RST;
    end else begin
      q <= d;
    end
  end

  assign counter_value         = q.cnt;
  assign channel_compare_value = q.cmp;
  assign overflow_flag         = q.ovf_f;
  assign overflow_irq          = q.ovf_irq;
  assign channel_event_flag    = q.ch_f;
  assign channel_irq           = q.ch_irq;
  assign channel_pin_out       = q.pin;
  assign channel_pin_oe        = q.oe;
  assign pair_active_odd       = q.act;
  assign wake_request          = q.wake;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence ovf_read_s;
    overflow_flag_read && overflow_flag && clr_ok && !ovf_ev;
  endsequence
  sequence ovf_wr0_s;
    overflow_flag_clear_wr && clr_ok && !ovf_ev;
  endsequence

  cnt_wrap_a: assert property (ovf_ev |=> counter_value == '0) // RULE23
    else $error("counter did not restart after period limit");
  ovf_set_a: assert property (ovf_ev |=> overflow_flag) // RULE13
    else $error("overflow flag not set");
  ovf_irq_a: assert property (overflow_irq |-> overflow_flag && $past(overflow_irq_enable)) // RULE25
    else $error("overflow request without flag and enable");
  ch_irq_a: assert property (channel_irq[0] |-> channel_event_flag[0]
    && $past(channel_irq_enable[0])) // RULE14
    else $error("channel request without flag and enable");
  wake_req_a: assert property ((overflow_irq || channel_irq != 4'h0) |-> wake_request) // RULE15
    else $error("enabled request did not wake");
  break_halt_a: assert property (debug_break && !counter_reset |=> $stable(counter_value)) // RULE17
    else $error("counter moved during break");
  break_keep_a: assert property (debug_break && !break_clear_enable && overflow_flag
    |=> overflow_flag) // RULE18
    else $error("flag cleared during protected break");
  flag_clear_a: assert property (ovf_read_s ##1 ovf_wr0_s |=> !overflow_flag) // RULE22
    else $error("two-step clear failed");
  link_gpio_a: assert property (buffer_mode_select[0] |=> !channel_pin_oe[1]) // RULE4
    else $error("odd pin still driven while linked");
  act_sync_a: assert property ($rose(pair_active_odd[0]) |-> $past(ovf_ev)) // RULE2
    else $error("active channel switched off overflow");
  zero_duty_a: assert property (single_mode_select[0] && !buffer_mode_select[0]
    && edge_level_select[1:0] == tiu_pkg::ELS_CLEAR && !toggle_on_overflow[0]
    && !channel_pin_out[0] |=> !channel_pin_out[0]) // RULE10
    else $error("output left 0 percent duty");
  full_duty_a: assert property (single_mode_select[0] && !buffer_mode_select[0]
    && edge_level_select[1:0] == tiu_pkg::ELS_CLEAR && toggle_on_overflow[0]
    && max_duty_bit[0] |=> channel_pin_out[0]) // RULE11
    else $error("output not held at 100 percent duty");
endmodule
`default_nettype wire

//--- design/tiu_tick_if.sv
`default_nettype none
interface tiu_tick_if;
  logic       run;
  logic       clr;
  logic [2:0] ps;
  logic       ext_clk;
  logic       tick;
  modport pre  (input run, clr, ps, ext_clk, output tick);
  modport core (output run, clr, ps, ext_clk, input tick);
endinterface
`default_nettype wire

//--- dv/tb_tiu_pwm_timer.sv
`default_nettype none
module tb_tiu_pwm_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;
  logic        reset = 1'b1, counter_halt = 1'b1, counter_reset = 1'b0;
  logic        overflow_irq_enable = 1'b0, break_clear_enable = 1'b0, debug_break = 1'b0;
  logic        stop_mode = 1'b0, external_count_clock = 1'b0;
  logic        overflow_flag_read = 1'b0, overflow_flag_clear_wr = 1'b0;
  logic [2:0]  prescale_select = 3'h0;
  logic [15:0] period_limit = 16'h0000, compare_wr_data = 16'h0000;
  logic [3:0]  buffer_mode_select = 4'h0, single_mode_select = 4'h0;
  logic [3:0]  toggle_on_overflow = 4'h0, max_duty_bit = 4'h0, channel_irq_enable = 4'h0;
  logic [3:0]  compare_wr = 4'h0, channel_flag_read = 4'h0, channel_flag_clear_wr = 4'h0;
  logic [3:0]  channel_pin_in = 4'h0;
  logic [7:0]  edge_level_select = 8'h00;
  logic [15:0] counter_value;
  logic [63:0] channel_compare_value;
  logic        overflow_flag, overflow_irq, wake_request;
  logic [3:0]  channel_event_flag, channel_irq, channel_pin_out, channel_pin_oe;
  logic [1:0]  pair_active_odd;
  int          n_errors = 0;
  int          num_checks = 0;

  tiu_pwm_timer #(.CW(16)) tiu_pwm_timer_i (
    .mclk, .reset, .counter_halt, .counter_reset, .prescale_select, .period_limit,
    .overflow_irq_enable, .break_clear_enable, .debug_break, .stop_mode,
    .external_count_clock, .overflow_flag_read, .overflow_flag_clear_wr,
    .buffer_mode_select, .single_mode_select, .edge_level_select, .toggle_on_overflow,
    .max_duty_bit, .channel_irq_enable, .compare_wr, .compare_wr_data, .channel_flag_read,
    .channel_flag_clear_wr, .channel_pin_in, .counter_value, .channel_compare_value,
    .overflow_flag, .overflow_irq, .channel_event_flag, .channel_irq, .channel_pin_out,
    .channel_pin_oe, .pair_active_odd, .wake_request
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // external count clock, 16 bus cycles a period
  initial begin
    forever begin
      repeat (8) @(posedge mclk);
      external_count_clock <= ~external_count_clock;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic run(input logic h);
    @(posedge mclk);
    counter_halt <= h;
  endtask

  // halt, clear counter and prescaler, set period, drop mode, toggle and max duty setup
  task automatic start(input logic [2:0] ps, input logic [15:0] per);
    @(posedge mclk);
    counter_halt <= 1'b1;
    counter_reset <= 1'b1;
    prescale_select <= ps;
    period_limit <= per;
    buffer_mode_select <= 4'h0;
    single_mode_select <= 4'h0;
    toggle_on_overflow <= 4'h0;
    max_duty_bit <= 4'h0;
    @(posedge mclk);
    counter_reset <= 1'b0;
  endtask

  task automatic cfg(input int c, input logic b, s, input logic [1:0] e, input logic t, m);
    @(posedge mclk);
    buffer_mode_select[c] <= b;
    single_mode_select[c] <= s;
    edge_level_select[2*c+:2] <= e;
    toggle_on_overflow[c] <= t;
    max_duty_bit[c] <= m;
  endtask

  task automatic wr(input int c, input logic [15:0] v);
    @(posedge mclk);
    compare_wr <= 4'h1 << c;
    compare_wr_data <= v;
    @(posedge mclk);
    compare_wr <= 4'h0;
  endtask

  task automatic pulse_of(input logic rd);
    @(posedge mclk);
    overflow_flag_read <= rd;
    overflow_flag_clear_wr <= ~rd;
    @(posedge mclk);
    overflow_flag_read <= 1'b0;
    overflow_flag_clear_wr <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic hi(input int b, output int h);
    h = 0;
    repeat (100) begin
      @(negedge mclk);
      h += int'(channel_pin_out[b]);
    end
  endtask

  task automatic t_ovf();
    int mx;
    logic [15:0] pv;
    start(3'h0, 16'h0009);
    overflow_irq_enable <= 1'b1;
    run(1'b0);
    mx = 0;
    pv = 16'h0000;
    repeat (40) begin
      @(negedge mclk);
      if (pv == 16'h0009) chk("wrap", counter_value, 0);
      if (counter_value > mx) mx = counter_value;
      pv = counter_value;
    end
    chk("max count", mx, 9);
    run(1'b1);
    cyc(1);
    chk("overflow flag", overflow_flag, 1);
    chk("overflow irq", overflow_irq, 1);
    chk("wake", wake_request, 1);
    pulse_of(1'b0);
    chk("clear without read", overflow_flag, 1);
    pulse_of(1'b1);
    run(1'b0);
    cyc(12);
    run(1'b1);
    pulse_of(1'b0);
    chk("event before write", overflow_flag, 1);
    @(posedge mclk);
    overflow_irq_enable <= 1'b0;
    cyc(2);
    chk("irq masked", {overflow_irq, wake_request}, 0);
    pulse_of(1'b1);
    pulse_of(1'b0);
    chk("flag cleared", overflow_flag, 0);
  endtask

  task automatic t_brk();
    logic [15:0] v;
    run(1'b0);
    cyc(12);
    @(posedge mclk);
    debug_break <= 1'b1;
    cyc(2);
    v = counter_value;
    cyc(5);
    chk("break halt", counter_value, v);
    @(posedge mclk);
    debug_break <= 1'b0;
    stop_mode <= 1'b1;
    cyc(2);
    v = counter_value;
    cyc(5);
    chk("stop halt", counter_value, v);
    @(posedge mclk);
    stop_mode <= 1'b0;
    counter_halt <= 1'b1;
    pulse_of(1'b1);
    @(posedge mclk);
    debug_break <= 1'b1;
    pulse_of(1'b0);
    chk("clear in break", overflow_flag, 1);
    @(posedge mclk);
    debug_break <= 1'b0;
    pulse_of(1'b0);
    chk("clear after break", overflow_flag, 0);
    run(1'b0);
    cyc(12);
    @(posedge mclk);
    counter_halt <= 1'b1;
    debug_break <= 1'b1;
    break_clear_enable <= 1'b1;
    pulse_of(1'b1);
    pulse_of(1'b0);
    chk("clear enabled in break", overflow_flag, 0);
    @(posedge mclk);
    debug_break <= 1'b0;
  endtask

  task automatic t_ps();
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      start(3'(i), 16'hFFFF);
      run(1'b0);
      cyc(70);
      v = counter_value;
      cyc(256);
      chk("prescale", 16'(counter_value - v), (i == 7) ? 16 : 256 >> i);
    end
  endtask

  task automatic meas(input logic [1:0] e, input logic [15:0] w, input logic t, m,
                      output int h);
    start(3'h0, 16'h0009);
    wr(0, w);
    cfg(0, 1'b0, 1'b1, e, t, m);
    channel_irq_enable[0] <= 1'b1;
    run(1'b0);
    cyc(20);
    hi(0, h);
  endtask

  task automatic t_pwm();
    int a;
    int b;
    int h;
    meas(tiu_pkg::ELS_CLEAR, 16'h0002, 1'b1, 1'b0, a);
    chk("compare flag", {channel_event_flag[0], channel_irq[0]}, 3);
    chk("pin driven", channel_pin_oe[0], 1);
    meas(tiu_pkg::ELS_CLEAR, 16'h0006, 1'b1, 1'b0, b);
    chk("width step", b - a, 40);
    meas(tiu_pkg::ELS_SET, 16'h0002, 1'b1, 1'b0, h);
    chk("low active", h, 100 - a);
    meas(tiu_pkg::ELS_CLEAR, 16'h0006, 1'b0, 1'b0, h);
    chk("zero duty", h, 0);
    meas(tiu_pkg::ELS_CLEAR, 16'h0006, 1'b1, 1'b1, h);
    chk("full duty", h, 100);
  endtask

  task automatic t_buf(input int p);
    int c;
    int a;
    int b;
    c = 2 * p;
    start(3'h0, 16'h0009);
    wr(c, 16'h0002);
    cfg(c, 1'b1, 1'b1, tiu_pkg::ELS_CLEAR, 1'b1, 1'b0);
    cfg(c + 1, 1'b0, 1'b1, tiu_pkg::ELS_SET, 1'b1, 1'b1);
    run(1'b0);
    cyc(20);
    hi(c, a);
    chk("even in control", pair_active_odd[p], 0);
    chk("odd pin released", channel_pin_oe[c+1], 0);
    run(1'b1);
    wr(c + 1, 16'h0006);
    cyc(3);
    chk("no early switch", pair_active_odd[p], 0);
    run(1'b0);
    cyc(20);
    chk("odd in control", pair_active_odd[p], 1);
    hi(c, b);
    chk("odd width", b - a, 40);
    wr(c, 16'h0004);
    cyc(20);
    chk("last written wins", pair_active_odd[p], 0);
  endtask

  // rising edge capture on channel 3, then two-step flag clear
  task automatic t_cap();
    start(3'h0, 16'h0009);
    cfg(3, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0);
    run(1'b0);
    cyc(5);
    @(posedge mclk);
    channel_pin_in[3] <= 1'b1;
    cyc(2);
    chk("capture flag", channel_event_flag[3], 1);
    chk("capture value", channel_compare_value[63:48], 4);
    @(posedge mclk);
    channel_irq_enable[3] <= 1'b1;
    cyc(2);
    chk("capture irq", channel_irq[3], 1);
    @(posedge mclk);
    channel_flag_read[3] <= 1'b1;
    @(posedge mclk);
    channel_flag_read[3] <= 1'b0;
    channel_flag_clear_wr[3] <= 1'b1;
    @(posedge mclk);
    channel_flag_clear_wr[3] <= 1'b0;
    cyc(1);
    chk("channel flag cleared", {channel_event_flag[3], channel_irq[3]}, 0);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    cyc(1);
    chk("reset counter", counter_value, 0);
    chk("reset outputs", {overflow_flag, overflow_irq, channel_event_flag, channel_irq,
        channel_pin_out, channel_pin_oe, pair_active_odd, wake_request}, 0);
    t_ovf();
    t_brk();
    t_ps();
    t_pwm();
    t_buf(0);
    t_buf(1);
    t_cap();
    final_report();
  end
endmodule
`default_nettype wire
